// file: design/airf_pkg.sv
// shared constants and state types for the airflow sample readout link
package airf_pkg;
    localparam logic [6:0] DEV_ADDR = 7'h28;
    localparam logic READ_BIT = 1'h1;
    localparam int FLOW_W = 12;
    localparam logic [11:0] FLOW_MIN = 12'h199;
    localparam logic [11:0] FLOW_MAX = 12'he66;
    localparam int PKT_BYTES = 5;
    localparam logic [2:0] LAST_IDX = 3'h4;
    localparam logic [2:0] LAST_BIT = 3'h7;
    localparam logic [3:0] ACK_SLOT = 4'h8;
    localparam int FIFO_DEPTH = 8;
    // bus timing: fast mode, the master's own divider
    localparam int CLK_PERIOD_NS = 10;
    localparam int SCL_PERIOD_NS = 2500;
    // least quarter period, rounded up so scl never beats 400 kHz
    localparam int QTR_CYC_I = (SCL_PERIOD_NS + 4 * CLK_PERIOD_NS - 1) / (4 * CLK_PERIOD_NS);
    localparam logic [6:0] QTR_CYC = 7'(QTR_CYC_I);
    localparam logic [6:0] QTR_RST = 7'h00;
    localparam logic SYNC_RST = 1'h1;
    typedef enum {DS_IDLE, DS_ADDR, DS_ADDR_ACK, DS_TX, DS_MACK} airf_dev_state_t;
    typedef enum {MS_IDLE, MS_START, MS_BITS, MS_STOP, MS_DONE} airf_mst_state_t;
endpackage

// file: design/airf_bus_if.sv
// two-wire link between the flow master and the sensor end
interface airf_bus_if;
    // master drives scl and sda, open drain, enables active low
    logic m_scl_o;
    logic m_scl_oe_n;
    logic m_sda_o;
    logic m_sda_oe_n;
    // sensor drives sda only
    logic s_sda_o;
    logic s_sda_oe_n;
    // resolved wire levels, pulled up when nobody drives
    logic scl;
    logic sda;
    assign scl = m_scl_oe_n | m_scl_o;
    assign sda = (m_sda_oe_n | m_sda_o) & (s_sda_oe_n | s_sda_o);
    modport mst (output m_scl_o, m_scl_oe_n, m_sda_o, m_sda_oe_n, input scl, sda);
    modport dev (output s_sda_o, s_sda_oe_n, input scl, sda);
endinterface

// file: design/airf_fifo.sv
// small synchronous fifo with valid/ready on both sides
module airf_fifo #(
    parameter int WIDTH = 12,
    parameter int DEPTH = 8
) (
    // system
    input wire logic clock,
    input wire logic reset,
    // fill side
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [WIDTH-1:0] in_data,
    // drain side
    output logic out_valid,
    input wire logic out_ready,
    output logic [WIDTH-1:0] out_data
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW:0] wr_q;
    logic [AW:0] rd_q;
    logic push;
    logic pop;

    assign in_ready = (wr_q[AW] == rd_q[AW]) || (wr_q[AW-1:0] != rd_q[AW-1:0]);
    assign out_valid = wr_q != rd_q;
    assign push = in_valid & in_ready;
    assign pop = out_valid & out_ready;
    assign out_data = mem[rd_q[AW-1:0]];

    always_ff @(posedge clock)
    begin
        if (push)
        begin
            mem[wr_q[AW-1:0]] <= in_data;
        end
    end

    always_ff @(posedge clock or posedge reset)
    begin
        if (reset)
        begin
            wr_q <= '0;
            rd_q <= '0;
        end
        else
        begin
            if (push)
            begin
                wr_q <= wr_q + 1'b1;
            end
            if (pop)
            begin
                rd_q <= rd_q + 1'b1;
            end
        end
    end
endmodule

// file: design/airf_sensor_dev.sv
// sensor end: two-wire slave returning checksum and flow bytes
//////////////////////////////////////////////////////////////////////////////
// Overview of operation
// - answer only address 0x28, ignore others
// - slave works at 100 and 400 kHz
// - start, sda falls with scl high
// - stop, sda rises with scl high
// - eight bits then one response bit
// - after ack, next byte or stop
// - slave pulls sda low to ack, releases
// - master treats undriven response as nack
// - sample on scl rise, change while low
// - measures continuously, no trigger needed
// - bytes go most significant bit first
// - master sends address then read bit 1
// - checksum first, then flow high, low
// - 12-bit flow, top four bits in low nibble of byte one
// - five bytes, last two repeat or zero
// - checksum is negated 8-bit data sum
// - master accepts when total sum is zero
// - flow count spans 409 to 3686
module airf_sensor_dev (
    // system
    input wire logic clock,
    input wire logic reset,
    // two-wire link
    airf_bus_if.dev bus,
    // live measurement side
    input wire logic [airf_pkg::FLOW_W-1:0] flow_count,
    input wire logic repeat_en,
    // status
    output logic busy,
    output logic packet_taken
);
    //////////////////////////////////////////////////////////////////////////
    logic scl_s1_q;
    logic scl_s2_q;
    logic scl_s3_q;
    logic sda_s1_q;
    logic sda_s2_q;
    logic sda_s3_q;
    logic scl_rise;
    logic scl_fall;
    logic start_det;
    logic stop_det;
    airf_pkg::airf_dev_state_t state_q;
    logic [2:0] bit_q;
    logic [2:0] idx_q;
    logic [7:0] sh_q;
    logic [7:0] tx_q;
    logic drive_q;
    logic ack_on_q;
    logic mack_q;
    logic taken_q;
    logic [11:0] flow_q;
    logic rep_q;
    logic [11:0] flow_lim;
    logic [7:0] addr_byte;
    logic [7:0] first_byte;
    logic [7:0] next_byte;

    //////////////////////////////////////////////////////////////////////////
    // pins are asynchronous: two flops, then a third for edge finding
    always_ff @(posedge clock or posedge reset)
    begin
        if (reset)
        begin
            scl_s1_q <= airf_pkg::SYNC_RST;
            scl_s2_q <= airf_pkg::SYNC_RST;
            scl_s3_q <= airf_pkg::SYNC_RST;
            sda_s1_q <= airf_pkg::SYNC_RST;
            sda_s2_q <= airf_pkg::SYNC_RST;
            sda_s3_q <= airf_pkg::SYNC_RST;
        end
        else
        begin
            scl_s1_q <= bus.scl;
            scl_s2_q <= scl_s1_q;
            scl_s3_q <= scl_s2_q;
            sda_s1_q <= bus.sda;
            sda_s2_q <= sda_s1_q;
            sda_s3_q <= sda_s2_q;
        end
    end

    // sampling at 100 MHz sees both bit rates with ample margin
    assign scl_rise = scl_s2_q & ~scl_s3_q;
    assign scl_fall = ~scl_s2_q & scl_s3_q;
    assign start_det = scl_s2_q & scl_s3_q & sda_s3_q & ~sda_s2_q;
    assign stop_det = scl_s2_q & scl_s3_q & ~sda_s3_q & sda_s2_q;
    assign addr_byte = {sh_q[6:0], sda_s2_q};

    //////////////////////////////////////////////////////////////////////////
    // packet contents, built from a snapshot taken at address match
    function automatic logic [7:0] pkt_byte(input logic [2:0] idx,
                                           input logic [11:0] flow,
                                           input logic rep);
        logic [7:0] hi;
        logic [7:0] lo;
        logic [7:0] sum;
        hi = {4'h0, flow[11:8]};
        lo = flow[7:0];
        sum = rep ? 8'(2 * (hi + lo)) : 8'(hi + lo);
        case (idx)
            3'h0: pkt_byte = 8'h00 - sum;
            3'h1: pkt_byte = hi;
            3'h2: pkt_byte = lo;
            3'h3: pkt_byte = rep ? hi : 8'h00;
            3'h4: pkt_byte = rep ? lo : 8'h00;
            default: pkt_byte = 8'h00;
        endcase
    endfunction

    // a function result cannot be bit-selected, so the bytes get nets of their own
    assign first_byte = pkt_byte(3'h0, flow_q, rep_q);
    assign next_byte = pkt_byte(idx_q + 3'h1, flow_q, rep_q);

    // live value clamped to the documented count span
    assign flow_lim = (flow_count < airf_pkg::FLOW_MIN) ? airf_pkg::FLOW_MIN :
                      (flow_count > airf_pkg::FLOW_MAX) ? airf_pkg::FLOW_MAX :
                      flow_count;

    //////////////////////////////////////////////////////////////////////////
    // byte level sequencer; start and stop win over any state
    always_ff @(posedge clock or posedge reset)
    begin
        if (reset)
        begin
            state_q <= airf_pkg::DS_IDLE;
            bit_q <= '0;
            idx_q <= '0;
            sh_q <= '0;
            tx_q <= '0;
            drive_q <= 1'b0;
            ack_on_q <= 1'b0;
            mack_q <= 1'b0;
            taken_q <= 1'b0;
            flow_q <= airf_pkg::FLOW_MIN;
            rep_q <= 1'b0;
        end
        else
        begin
            taken_q <= 1'b0;
            if (stop_det)
            begin
                state_q <= airf_pkg::DS_IDLE;
                drive_q <= 1'b0;
            end
            else if (start_det)
            begin
                state_q <= airf_pkg::DS_ADDR;
                bit_q <= '0;
                drive_q <= 1'b0;
                ack_on_q <= 1'b0;
            end
            else
            begin
                case (state_q)
                    airf_pkg::DS_IDLE:
                    begin
                        drive_q <= 1'b0;
                    end
                    airf_pkg::DS_ADDR:
                    begin
                        if (scl_rise)
                        begin
                            sh_q <= addr_byte;
                            bit_q <= bit_q + 1'b1;
                            if (bit_q == airf_pkg::LAST_BIT)
                            begin
                                if (addr_byte == {airf_pkg::DEV_ADDR, airf_pkg::READ_BIT})
                                begin
                                    state_q <= airf_pkg::DS_ADDR_ACK;
                                    flow_q <= flow_lim;
                                    rep_q <= repeat_en;
                                    idx_q <= '0;
                                    taken_q <= 1'b1;
                                end
                                else
                                begin
                                    state_q <= airf_pkg::DS_IDLE;
                                end
                            end
                        end
                    end
                    airf_pkg::DS_ADDR_ACK:
                    begin
                        if (scl_fall)
                        begin
                            if (!ack_on_q)
                            begin
                                ack_on_q <= 1'b1;
                                drive_q <= 1'b1;
                            end
                            else
                            begin
                                ack_on_q <= 1'b0;
                                state_q <= airf_pkg::DS_TX;
                                bit_q <= '0;
                                tx_q <= first_byte;
                                drive_q <= ~first_byte[7];
                            end
                        end
                    end
                    airf_pkg::DS_TX:
                    begin
                        // data only changes after scl has fallen
                        if (scl_fall)
                        begin
                            if (bit_q == airf_pkg::LAST_BIT)
                            begin
                                drive_q <= 1'b0;
                                state_q <= airf_pkg::DS_MACK;
                            end
                            else
                            begin
                                tx_q <= {tx_q[6:0], 1'b0};
                                drive_q <= ~tx_q[6];
                                bit_q <= bit_q + 1'b1;
                            end
                        end
                    end
                    airf_pkg::DS_MACK:
                    begin
                        if (scl_rise)
                        begin
                            mack_q <= ~sda_s2_q;
                        end
                        if (scl_fall)
                        begin
                            if (mack_q && idx_q != airf_pkg::LAST_IDX)
                            begin
                                idx_q <= idx_q + 1'b1;
                                state_q <= airf_pkg::DS_TX;
                                bit_q <= '0;
                                tx_q <= next_byte;
                                drive_q <= ~next_byte[7];
                            end
                            else
                            begin
                                state_q <= airf_pkg::DS_IDLE;
                            end
                        end
                    end
                    default:
                    begin
                        state_q <= airf_pkg::DS_IDLE;
                    end
                endcase
            end
        end
    end

    //////////////////////////////////////////////////////////////////////////
    // open drain: only ever pulls low
    assign bus.s_sda_o = 1'b0;
    assign bus.s_sda_oe_n = ~drive_q;
    assign busy = state_q != airf_pkg::DS_IDLE;
    assign packet_taken = taken_q;
endmodule

// file: design/airf_flow_master.sv
// master end: polls the sensor, checks the packet, queues flow counts
module airf_flow_master (
    // system
    input wire logic clock,
    input wire logic reset,
    // two-wire link
    airf_bus_if.mst bus,
    // control
    input wire logic poll_en,
    // flow count stream
    output logic flow_valid,
    input wire logic flow_ready,
    output logic [airf_pkg::FLOW_W-1:0] flow_data,
    // status pulses
    output logic sum_err,
    output logic addr_nack
);
    //////////////////////////////////////////////////////////////////////////
    airf_pkg::airf_mst_state_t state_q;
    logic [6:0] qcnt_q;
    logic [1:0] q_q;
    logic [3:0] bitn_q;
    logic [2:0] byte_q;
    logic sda_low_q;
    logic sda_s1_q;
    logic sda_s2_q;
    logic [39:0] rx_q;
    logic push_q;
    logic sum_err_q;
    logic nack_q;
    logic tick;
    logic scl_high;
    logic fifo_in_ready;
    logic [7:0] addr_byte;
    logic [7:0] total;

    assign addr_byte = {airf_pkg::DEV_ADDR, airf_pkg::READ_BIT};
    assign tick = qcnt_q == airf_pkg::QTR_CYC - 7'h01;
    // checksum plus four data bytes must wrap to zero
    assign total = 8'(rx_q[39:32] + rx_q[31:24] + rx_q[23:16] + rx_q[15:8] + rx_q[7:0]);

    //////////////////////////////////////////////////////////////////////////
    always_ff @(posedge clock or posedge reset)
    begin
        if (reset)
        begin
            sda_s1_q <= airf_pkg::SYNC_RST;
            sda_s2_q <= airf_pkg::SYNC_RST;
        end
        else
        begin
            sda_s1_q <= bus.sda;
            sda_s2_q <= sda_s1_q;
        end
    end

    always_ff @(posedge clock or posedge reset)
    begin
        if (reset)
        begin
            qcnt_q <= airf_pkg::QTR_RST;
        end
        else if (tick || state_q == airf_pkg::MS_IDLE)
        begin
            qcnt_q <= airf_pkg::QTR_RST;
        end
        else
        begin
            qcnt_q <= qcnt_q + 7'h01;
        end
    end

    //////////////////////////////////////////////////////////////////////////
    // each bit is four quarters: low, low with new data, high, high
    always_ff @(posedge clock or posedge reset)
    begin
        if (reset)
        begin
            state_q <= airf_pkg::MS_IDLE;
            q_q <= '0;
            bitn_q <= '0;
            byte_q <= '0;
            sda_low_q <= 1'b0;
            rx_q <= '0;
            push_q <= 1'b0;
            sum_err_q <= 1'b0;
            nack_q <= 1'b0;
        end
        else
        begin
            push_q <= 1'b0;
            sum_err_q <= 1'b0;
            case (state_q)
                airf_pkg::MS_IDLE:
                begin
                    sda_low_q <= 1'b0;
                    q_q <= '0;
                    nack_q <= 1'b0;
                    // wait for the last push to land, else a full fifo still looks ready
                    if (poll_en && fifo_in_ready && !push_q)
                    begin
                        state_q <= airf_pkg::MS_START;
                    end
                end
                airf_pkg::MS_START:
                begin
                    if (tick)
                    begin
                        q_q <= q_q + 2'h1;
                        if (q_q == 2'h1)
                        begin
                            sda_low_q <= 1'b1;
                        end
                        if (q_q == 2'h3)
                        begin
                            state_q <= airf_pkg::MS_BITS;
                            bitn_q <= '0;
                            byte_q <= '0;
                        end
                    end
                end
                airf_pkg::MS_BITS:
                begin
                    if (tick)
                    begin
                        q_q <= q_q + 2'h1;
                        if (q_q == 2'h0)
                        begin
                            if (bitn_q != airf_pkg::ACK_SLOT)
                            begin
                                sda_low_q <= (byte_q == 3'h0) ? ~addr_byte[3'h7 - bitn_q[2:0]] : 1'b0;
                            end
                            else
                            begin
                                sda_low_q <= byte_q != 3'h0 && byte_q != 3'(airf_pkg::PKT_BYTES);
                            end
                        end
                        if (q_q == 2'h2 && byte_q != 3'h0 && bitn_q != airf_pkg::ACK_SLOT)
                        begin
                            rx_q <= {rx_q[38:0], sda_s2_q};
                        end
                        if (q_q == 2'h2 && byte_q == 3'h0 && bitn_q == airf_pkg::ACK_SLOT)
                        begin
                            nack_q <= sda_s2_q;
                        end
                        if (q_q == 2'h3)
                        begin
                            bitn_q <= (bitn_q == airf_pkg::ACK_SLOT) ? 4'h0 : bitn_q + 4'h1;
                            if (bitn_q == airf_pkg::ACK_SLOT)
                            begin
                                byte_q <= byte_q + 3'h1;
                                if (nack_q || byte_q == 3'(airf_pkg::PKT_BYTES))
                                begin
                                    state_q <= airf_pkg::MS_STOP;
                                end
                            end
                        end
                    end
                end
                airf_pkg::MS_STOP:
                begin
                    if (tick)
                    begin
                        q_q <= q_q + 2'h1;
                        if (q_q == 2'h0)
                        begin
                            sda_low_q <= 1'b1;
                        end
                        if (q_q == 2'h2)
                        begin
                            sda_low_q <= 1'b0;
                        end
                        if (q_q == 2'h3)
                        begin
                            state_q <= (byte_q == 3'h1) ? airf_pkg::MS_IDLE : airf_pkg::MS_DONE;
                        end
                    end
                end
                airf_pkg::MS_DONE:
                begin
                    push_q <= total == 8'h00;
                    sum_err_q <= total != 8'h00;
                    state_q <= airf_pkg::MS_IDLE;
                end
                default:
                begin
                    state_q <= airf_pkg::MS_IDLE;
                end
            endcase
        end
    end

    //////////////////////////////////////////////////////////////////////////
    assign scl_high = (state_q == airf_pkg::MS_IDLE) || (state_q == airf_pkg::MS_DONE) ||
                      (state_q == airf_pkg::MS_START && q_q != 2'h3) ||
                      (state_q != airf_pkg::MS_START && q_q[1]);
    assign bus.m_scl_o = 1'b0;
    assign bus.m_scl_oe_n = scl_high;
    assign bus.m_sda_o = 1'b0;
    assign bus.m_sda_oe_n = ~sda_low_q;
    assign sum_err = sum_err_q;
    assign addr_nack = nack_q && state_q == airf_pkg::MS_STOP && q_q == 2'h0 && tick;

    // only one read in flight and it starts only with room, so push never stalls
    airf_fifo #(
        .WIDTH(airf_pkg::FLOW_W),
        .DEPTH(airf_pkg::FIFO_DEPTH)
    ) u_fifo (
        .clock(clock),
        .reset(reset),
        .in_valid(push_q),
        .in_ready(fifo_in_ready),
        .in_data({rx_q[27:24], rx_q[23:16]}),
        .out_valid(flow_valid),
        .out_ready(flow_ready),
        .out_data(flow_data)
    );
endmodule

// file: verification/airf_link_chk.sv
// wire-level checker for the two-wire flow link
module airf_link_chk (
    // system
    input wire logic clock,
    input wire logic reset,
    // resolved wire and sensor drive
    input wire logic scl,
    input wire logic sda,
    input wire logic s_sda_oe_n
);
    timeunit 1ns;
    timeprecision 1ps;
    localparam logic [7:0] ADDR_RD = {airf_pkg::DEV_ADDR, airf_pkg::READ_BIT};
    logic scl_q, sda_q, frm_q, rise, start, stop;
    logic [5:0] n_q, n;
    logic [39:0] d_q;
    logic [7:0] psum;
    assign rise = scl & ~scl_q & frm_q;
    assign start = scl & scl_q & sda_q & ~sda;
    assign stop = scl & scl_q & ~sda_q & sda & frm_q;
    assign n = n_q + 6'h01;
    assign psum = d_q[39:32] + d_q[31:24] + d_q[23:16] + d_q[15:8] + d_q[7:0];
    ////////////////////////////////////////////////////////////////////////////
    always_ff @(posedge clock or posedge reset)
    begin
        if (reset)
            {scl_q, sda_q, frm_q} <= 3'h6;
        else
            {scl_q, sda_q, frm_q} <= {scl, sda, start | (frm_q & ~stop)};
    end
    // scl rises since the last start, the stop's own rise included
    always_ff @(posedge clock or posedge reset)
    begin
        if (reset)
            n_q <= 6'h00;
        else if (start)
            n_q <= 6'h00;
        else if (rise)
            n_q <= n;
    end
    // ack slots skipped, so only the five data bytes land here
    always_ff @(posedge clock or posedge reset)
    begin
        if (reset)
            d_q <= 40'h0;
        else if (rise && n > 6'h09 && n < 6'h36 && (n % 6'h09) != 6'h00)
            d_q <= {d_q[38:0], sda};
    end
    ////////////////////////////////////////////////////////////////////////////
    default clocking cb @(posedge clock);
    endclocking
    default disable iff (reset);
    sequence s_addr_ack;
        rise && n == 6'h09;
    endsequence
    sequence s_mst_ack;
        rise && (n == 6'h12 || n == 6'h1b || n == 6'h24 || n == 6'h2d);
    endsequence
    AST_SLV_HOLD: assert property (scl && $past(scl) |-> $stable(s_sda_oe_n))
        else $error("sensor moved sda while scl high");
    AST_IDLE_FREE: assert property (!frm_q |-> s_sda_oe_n)
        else $error("sensor drove sda outside a frame");
    AST_ADDR_BITS: assert property (rise && n < 6'h09 |-> sda == ADDR_RD[3'(6'h08 - n)])
        else $error("address byte wrong on wire");
    AST_ADDR_ACK: assert property (s_addr_ack |-> !sda && !s_sda_oe_n)
        else $error("sensor did not ack its address");
    AST_MST_ACK: assert property (s_mst_ack |-> !sda && s_sda_oe_n)
        else $error("ack slot of a sent byte wrong");
    AST_LAST_NACK: assert property (rise && n == 6'h36 |-> sda)
        else $error("last byte not refused");
    AST_FRAME_LEN: assert property (stop |-> n_q == 6'h37)
        else $error("frame not five data bytes");
    AST_CHK_SUM: assert property (stop |-> psum == 8'h00)
        else $error("checksum does not cancel data sum");
    AST_FLOW_FMT: assert property (stop |-> d_q[31:28] == 4'h0 && d_q[27:16] >= airf_pkg::FLOW_MIN
        && d_q[27:16] <= airf_pkg::FLOW_MAX)
        else $error("flow bytes malformed");
    AST_TAIL: assert property (stop |-> d_q[15:0] == d_q[31:16] || d_q[15:0] == 16'h0)
        else $error("tail bytes neither repeat nor zero");
endmodule

// file: verification/tb.sv
// top bench: master polls the sensor until the fifo refuses, then drains it
module tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic clock = 1'h0;
    logic reset = 1'h1;
    logic [11:0] flow_count = 12'h000;
    logic repeat_en = 1'h0;
    logic poll_en = 1'h0;
    logic flow_ready = 1'h0;
    logic busy, packet_taken, flow_valid, sum_err, addr_nack;
    logic [11:0] flow_data;
    logic [11:0] tab [8] = '{12'h000, 12'h198, 12'h199, 12'h7ab, 12'he66, 12'he67, 12'hfff,
        12'h123};
    int err_count = 0;
    int n_checks = 0;
    int cyc = 0;
    airf_bus_if bus ();
    airf_sensor_dev airf_sensor_dev_i (.clock(clock), .reset(reset), .bus(bus.dev),
        .flow_count(flow_count), .repeat_en(repeat_en), .busy(busy), .packet_taken(packet_taken));
    airf_flow_master airf_flow_master_i (.clock(clock), .reset(reset), .bus(bus.mst),
        .poll_en(poll_en), .flow_valid(flow_valid), .flow_ready(flow_ready),
        .flow_data(flow_data), .sum_err(sum_err), .addr_nack(addr_nack));
    airf_link_chk airf_link_chk_i (.clock(clock), .reset(reset), .scl(bus.scl), .sda(bus.sda),
        .s_sda_oe_n(bus.s_sda_oe_n));
    ////////////////////////////////////////////////////////////////////////////
    always #5 clock = ~clock;
    task automatic give_verdict();
        $display("checks %0d mismatches %0d", n_checks, err_count);
        if (err_count == 0 && n_checks > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask
    task automatic check(input string what, input logic [12:0] exp, input logic [12:0] got);
        n_checks++;
        if (got !== exp)
        begin
            err_count++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
        end
    endtask
    function automatic logic [11:0] clamp(input logic [11:0] v);
        return v < airf_pkg::FLOW_MIN ? airf_pkg::FLOW_MIN : v > airf_pkg::FLOW_MAX ?
            airf_pkg::FLOW_MAX : v;
    endfunction
    // present one measurement, wait for the sensor to latch it
    task automatic send_sample(input int i);
        int k;
        flow_count = tab[i];
        repeat_en = i[0];
        k = 0;
        do
        begin
            @(posedge clock);
            #1 k++;
        end
        while (packet_taken !== 1'h1 && k < 20000);
        check("packet taken", 13'h1, {12'h0, packet_taken});
        check("sensor busy", 13'h1, {12'h0, busy});
    endtask
    ////////////////////////////////////////////////////////////////////////////
    // status pulses are looked at mid-cycle, away from the edge that launches them
    always @(negedge clock)
    begin
        cyc++;
        if (!reset && (sum_err !== 1'h0 || addr_nack !== 1'h0))
        begin
            err_count++;
            $display("CHECK FAILED status pulse expected 0 seen 1");
        end
        if (cyc == 200000)
        begin
            err_count++;
            give_verdict();
        end
    end
    initial
    begin
        int k;
        repeat (16) @(posedge clock);
        #1 reset = 1'h0;
        poll_en = 1'h1;
        for (int i = 0; i < 8; i++)
            send_sample(i);
        // fifo full: master must stop polling, so no packet may follow
        k = 0;
        repeat (16000)
        begin
            @(posedge clock);
            #1 k += int'(packet_taken === 1'h1);
        end
        check("extra packets", 13'h0, 13'(k));
        poll_en = 1'h0;
        flow_ready = 1'h1;
        for (int i = 0; i < 8; i++)
        begin
            check("flow word", {1'h1, clamp(tab[i])}, {flow_valid, flow_data});
            @(posedge clock);
            #1;
        end
        flow_ready = 1'h0;
        check("fifo empty", 13'h0, {12'h0, flow_valid});
        check("sensor busy", 13'h0, {12'h0, busy});
        give_verdict();
    end
endmodule
